/* hdl/flash_erase_id.sv */
// Purpose: erase and identification command handling of a serial nor flash
// Assumes: host drives select, serial clock and serial input in mode 0
// Notes: select must stay high at least six system clocks between frames
`timescale 1ns/1ns
`include "flash_cmd_defines.svh"
module flash_erase_id
  import flash_cmd_pkg::*;
#(
  parameter int unsigned   BLOCK32_CYC = `BLOCK32_WIPE_TIME_US * `CLK_MHZ,
  parameter int unsigned   BLOCK64_CYC = `BLOCK64_WIPE_TIME_US * `CLK_MHZ,
  parameter int unsigned   FULL_CYC    = `FULL_WIPE_TIME_US * `CLK_MHZ,
  parameter int unsigned   SECTOR_CYC  = `SECTOR_WIPE_TIME_US * `CLK_MHZ,
  parameter logic [7:0]    MAKER_CODE  = 8'h5a,   // arbitrary value
  parameter logic [7:0]    DEVICE_CODE = 8'h14,   // arbitrary value
  parameter logic [7:0]    MEM_TYPE    = 8'h40,   // arbitrary value
  parameter logic [7:0]    CAPACITY    = 8'h15,   // arbitrary value
  parameter logic [127:0]  UNIQUE_ID   = 128'h0123_4567_89ab_cdef_fedc_ba98_7654_3210  // arbitrary value
) (
  input  wire logic        clk,
  input  wire logic        rst_n,
  input  wire logic        sclk,
  input  wire logic        cs_n,
  input  wire logic        si,
  input  wire logic        protect_level_0,
  input  wire logic        protect_level_1,
  input  wire logic        protect_level_2,
  input  wire logic        protect_level_3,
  input  wire logic        protect_level_4,
  input  wire logic        protect_invert,
  input  wire logic        otp_lock_0,
  input  wire logic        otp_lock_1,
  output logic             so,
  output logic             so_oe,
  output logic             op_in_progress,
  output logic             write_latch_flag,
  output wipe_kind_t       wipe_kind,
  output logic [23:0]      wipe_base,
  output logic             wipe_done
);

  ////////////////////////////////////////////////////////////////////////////
  // declarations

  logic [7:0]     bit_cnt;        // link bit count
  logic [7:0]     opcode;         // captured opcode
  logic [31:0]    word;           // last 32 bits in
  logic [7:0]     frame_bits;     // bits of the ended frame
  logic           req;            // link frame toggle
  logic           req_s;          // toggle in system domain
  logic           cs_hi;          // filtered select level
  logic           cs_prev_q;      // select level last cycle
  logic           ack_q;          // frames consumed toggle
  logic           eval_w;         // a new frame just ended
  logic [23:0]    addr_w;         // address of the frame
  logic [4:0]     levels_w;       // protect levels gathered
  logic           blk_prot_w;     // target block protected
  logic           chip_ok_w;      // full wipe allowed
  logic           op_is_blk_w;    // complete block wipe frame
  logic           accept_w;       // command valid apart from latch
  logic           start_w;        // wipe starts this cycle
  logic           wel_set_w;      // write enable seen
  wipe_kind_t     kind_d;         // kind to start
  logic [23:0]    base_d;         // base to start
  logic [31:0]    cycles_d;       // duration to start
  engine_state_t  state_q;        // engine state
  logic [31:0]    count_q;        // cycles left
  logic           busy_q;         // busy flag register
  logic           wel_q;          // write latch register
  wipe_kind_t     kind_q;         // running kind
  logic [23:0]    base_q;         // running base
  logic           done_q;         // completion pulse
  logic           busy_s1_q;      // busy to link, stage one
  logic           busy_s2_q;      // busy to link, stage two
  logic           busy_s3_q;      // busy to link, stage three
  logic           busy_lk_q;      // busy once stages agree
  logic           id_ok_q;        // ident read decoded
  logic           out_en_w;       // output phase active
  logic           out_bit_w;      // bit to drive next
  logic [7:0]     idx_w;          // output bit index
  logic           so_q;           // output data register
  logic           so_oe_q;        // output enable register
  localparam logic [23:0] IDENT_BITS = {MAKER_CODE, MEM_TYPE, CAPACITY};  // ident read word
  localparam logic [15:0] PAIR_BITS  = {MAKER_CODE, DEVICE_CODE};         // maker, device pair

  ////////////////////////////////////////////////////////////////////////////
  // functions

  // block protection test on the 64KB block number of an address
  function automatic logic blk_protected(
    input logic [23:0] a,
    input logic [4:0]  lv,
    input logic        inv
  );
    logic [6:0] n;
    logic [6:0] blk;
    logic       hit;
    n   = 7'h01 << (lv[2:0] - 3'h1);
    blk = {2'b00, a[20:16]};
    hit = lv[3] ? (blk < n) : (blk + n >= `ARRAY_BLOCKS);
    return ((lv[2:0] != 3'h0) & hit) ^ inv;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // link side input

  // shifter on the serial clock
  spi_link_shift u_shift (
    .sclk       (sclk),
    .cs_n       (cs_n),
    .si         (si),
    .ack        (ack_q),
    .bit_cnt_q  (bit_cnt),
    .opcode_q   (opcode),
    .word_q     (word),
    .last_cnt_q (frame_bits),
    .req_q      (req)
  );

  // select pin into the system domain
  sync_agree3 #(.INIT(1'b1)) u_cs_sync (
    .clk   (clk),
    .rst_n (rst_n),
    .din   (cs_n),
    .dout  (cs_hi)
  );

  // frame toggle into the system domain
  sync_agree3 #(.INIT(1'b0)) u_req_sync (
    .clk   (clk),
    .rst_n (rst_n),
    .din   (req),
    .dout  (req_s)
  );

  ////////////////////////////////////////////////////////////////////////////
  // frame end detection

  // select rise with a new frame behind it; words are still by now
  assign eval_w = cs_hi & ~cs_prev_q & (req_s != ack_q);
  assign addr_w = word[23:0];

  // remember select level and consume frames
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      cs_prev_q <= 1'b1;
      ack_q     <= 1'b0;
    end
    else
    begin
      cs_prev_q <= cs_hi;
      if (cs_hi & ~cs_prev_q)
        ack_q <= req_s;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // command decode

  // protection inputs
  assign levels_w    = {protect_level_4, protect_level_3, protect_level_2, protect_level_1, protect_level_0};
  assign blk_prot_w  = blk_protected(addr_w, levels_w, protect_invert);
  // full wipe needs levels 2-0 all zero and plain, or all one and inverted; levels 3 and 4 not looked at
  assign chip_ok_w   = ((levels_w[2:0] == 3'h0) & ~protect_invert) |
                       ((levels_w[2:0] == 3'h7) & protect_invert);
  assign op_is_blk_w = eval_w & (frame_bits == `ADDR_CMD_BITS) &
                       ((opcode == `OP_BLOCK32) | (opcode == `OP_BLOCK64));

  // decode of the ended frame; nothing accepted while busy
  always_comb
  begin
    kind_d    = WIPE_NONE;
    base_d    = 24'h000000;
    cycles_d  = 32'h00000001;
    accept_w  = 1'b0;
    wel_set_w = 1'b0;
    if (eval_w && state_q == ST_IDLE)
    begin
      case (opcode)
        `OP_WRITE_ENABLE:
        begin
          wel_set_w = (frame_bits == `OP_BITS);
        end
        `OP_BLOCK32:
        begin
          // aligned 32KB block, exact frame length, not protected
          kind_d   = WIPE_BLOCK32;
          base_d   = {addr_w[23:15], 15'h0000};
          cycles_d = BLOCK32_CYC;
          accept_w = (frame_bits == `ADDR_CMD_BITS) & ~blk_prot_w;
        end
        `OP_BLOCK64:
        begin
          // aligned 64KB block
          kind_d   = WIPE_BLOCK64;
          base_d   = {addr_w[23:16], 16'h0000};
          cycles_d = BLOCK64_CYC;
          accept_w = (frame_bits == `ADDR_CMD_BITS) & ~blk_prot_w;
        end
        `OP_CHIP_A, `OP_CHIP_B:
        begin
          // opcode only, then release
          kind_d   = WIPE_CHIP;
          cycles_d = FULL_CYC;
          accept_w = (frame_bits == `OP_BITS) & chip_ok_w;
        end
        `OP_OTP_WIPE:
        begin
          // register picked by bits 15-12, low ten bits ignored
          kind_d   = addr_w[12] ? WIPE_OTP1 : WIPE_OTP0;
          base_d   = {8'h00, addr_w[15:10], 10'h000};
          cycles_d = SECTOR_CYC;
          accept_w = (frame_bits == `ADDR_CMD_BITS) && (addr_w[23:16] == 8'h00) &&
                     (addr_w[15:13] == 3'h0) && (addr_w[11:10] == 2'h0) &&
                     !(addr_w[12] ? otp_lock_1 : otp_lock_0);
        end
        default:
        begin
          accept_w = 1'b0;
        end
      endcase
    end
  end

  // a wipe starts only with the write latch set
  assign start_w = accept_w & wel_q;

  ////////////////////////////////////////////////////////////////////////////
  // write latch

  // cleared at wipe start, set by write enable
  always_ff @(posedge clk)
  begin
    if (!rst_n)
      wel_q <= 1'b0;
    else if (start_w)
      wel_q <= 1'b0;
    else if (wel_set_w)
      wel_q <= 1'b1;
  end

  ////////////////////////////////////////////////////////////////////////////
  // wipe engine

  // self-timed cycle, busy for its whole length
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      state_q <= ST_IDLE;
      count_q <= 32'h00000000;
      busy_q  <= 1'b0;
      kind_q  <= WIPE_NONE;
      base_q  <= 24'h000000;
      done_q  <= 1'b0;
    end
    else
    begin
      done_q <= 1'b0;
      case (state_q)
        ST_IDLE:
        begin
          // start at the select release of a valid command
          if (start_w)
          begin
            state_q <= ST_WIPE;
            busy_q  <= 1'b1;
            count_q <= cycles_d;
            kind_q  <= kind_d;
            base_q  <= base_d;
          end
        end
        ST_WIPE:
        begin
          // count down, drop busy at the end
          if (count_q <= 32'h00000001)
          begin
            state_q <= ST_IDLE;
            busy_q  <= 1'b0;
            done_q  <= 1'b1;
          end
          else
            count_q <= count_q - 32'h00000001;
        end
        default:
        begin
          state_q <= ST_IDLE;
          busy_q  <= 1'b0;
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // link side output

  // busy into the link domain, moves once stages two and three agree
  always_ff @(posedge sclk)
  begin
    busy_s1_q <= busy_q;
    busy_s2_q <= busy_s1_q;
    busy_s3_q <= busy_s2_q;
    if (busy_s2_q == busy_s3_q)
      busy_lk_q <= busy_s3_q;
  end

  // ident read decoded only when idle at the opcode
  always_ff @(posedge sclk or posedge cs_n)
  begin
    if (cs_n)
      id_ok_q <= 1'b0;
    else if (bit_cnt == 8'h07)
      id_ok_q <= ~busy_lk_q;
  end

  // output bit selection per opcode
  always_comb
  begin
    out_en_w  = 1'b0;
    out_bit_w = 1'b0;
    idx_w     = 8'h00;
    case (opcode)
      `OP_IDENT:
      begin
        // maker, type, capacity
        idx_w     = bit_cnt - `IDENT_START;
        out_en_w  = id_ok_q && (bit_cnt >= `IDENT_START) && (bit_cnt < `IDENT_END);
        out_bit_w = IDENT_BITS[5'd23 - idx_w[4:0]];
      end
      `OP_MAKER_DEV:
      begin
        // maker then device, repeating
        idx_w     = bit_cnt - `MAKER_DEV_START;
        out_en_w  = (bit_cnt >= `MAKER_DEV_START);
        out_bit_w = PAIR_BITS[~idx_w[3:0]];
      end
      `OP_UNIQUE:
      begin
        // fixed 128 bits after address and dummy
        idx_w     = bit_cnt - `UNIQUE_START;
        out_en_w  = (bit_cnt >= `UNIQUE_START) && (bit_cnt < `UNIQUE_END);
        out_bit_w = UNIQUE_ID[~idx_w[6:0]];
      end
      default:
      begin
        out_en_w = 1'b0;
      end
    endcase
  end

  // drive on falling edges, stop at once on select release
  always_ff @(negedge sclk or posedge cs_n)
  begin
    if (cs_n)
    begin
      so_q    <= 1'b0;
      so_oe_q <= 1'b0;
    end
    else
    begin
      so_q    <= out_bit_w;
      so_oe_q <= out_en_w;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // outputs

  assign so               = so_q;
  assign so_oe            = so_oe_q;
  assign op_in_progress   = busy_q;
  assign write_latch_flag = wel_q;
  assign wipe_kind        = kind_q;
  assign wipe_base        = base_q;
  assign wipe_done        = done_q;

  ////////////////////////////////////////////////////////////////////////////
  // assertions

  sequence s_accept;
    start_w;
  endsequence

  sequence s_running;
    busy_q && (count_q > 32'h00000001);
  endsequence

  property p_no_latch;
    @(posedge clk) disable iff (!rst_n) !busy_q && !wel_q |=> !busy_q;
  endproperty
  a_no_latch: assert property (p_no_latch) else $error("wipe started without write latch");

  property p_start_busy;
    @(posedge clk) disable iff (!rst_n) s_accept |=> busy_q && (count_q == $past(cycles_d));
  endproperty
  a_start_busy: assert property (p_start_busy) else $error("wipe did not start with its duration");

  property p_wel_drop;
    @(posedge clk) disable iff (!rst_n) s_accept |=> !wel_q;
  endproperty
  a_wel_drop: assert property (p_wel_drop) else $error("write latch not cleared at wipe");

  property p_hold;
    @(posedge clk) disable iff (!rst_n) s_running |=> busy_q;
  endproperty
  a_hold: assert property (p_hold) else $error("busy dropped early");

  property p_finish;
    @(posedge clk) disable iff (!rst_n) busy_q && (count_q == 32'h00000001) |=> !busy_q && done_q;
  endproperty
  a_finish: assert property (p_finish) else $error("busy not cleared at end");

  property p_align;
    @(posedge clk) disable iff (!rst_n) s_accept ##1 (kind_q == WIPE_BLOCK64) |-> (base_q[15:0] == 16'h0000);
  endproperty
  a_align: assert property (p_align) else $error("block base not aligned");

  property p_prot;
    @(posedge clk) disable iff (!rst_n) op_is_blk_w && blk_prot_w && !busy_q |=> !busy_q;
  endproperty
  a_prot: assert property (p_prot) else $error("protected block wiped");

  property p_chip;
    @(posedge clk) disable iff (!rst_n) s_accept and (kind_d == WIPE_CHIP) |-> chip_ok_w && (frame_bits == 8'h08);
  endproperty
  a_chip: assert property (p_chip) else $error("full wipe under protection");

  property p_lock;
    @(posedge clk) disable iff (!rst_n) s_accept and (kind_d == WIPE_OTP1) |-> !otp_lock_1;
  endproperty
  a_lock: assert property (p_lock) else $error("locked otp register wiped");

  property p_frame;
    @(posedge clk) disable iff (!rst_n) s_accept and (kind_d != WIPE_CHIP) |-> (frame_bits == 8'h20);
  endproperty
  a_frame: assert property (p_frame) else $error("addressed wipe with wrong length");

  property p_id_gate;
    @(negedge sclk) disable iff (cs_n) so_oe_q && (opcode == 8'h9f) |-> id_ok_q;
  endproperty
  a_id_gate: assert property (p_id_gate) else $error("ident read answered while busy");

endmodule // flash_erase_id

/* hdl/flash_cmd_defines.svh */
// Purpose: shared constants of the erase and identification command block
// Assumes: spi mode 0, msb first, one bit per rising serial clock
// Notes: times in microseconds, cycle counts derive from CLK_MHZ
// Function
// - 52h plus three address bytes: 32KB wipe
// - d8h plus three address bytes: 64KB wipe
// - any address wipes its whole aligned block
// - addressed wipe needs exactly 32 bits framed
// - wipe timer starts at select release
// - busy flag high for whole wipe
// - write latch cleared before wipe ends
// - protected blocks are never wiped
// - 60h or c7h alone: full wipe
// - full wipe only with levels 000/0 or 111/1
// - 90h plus zero address: maker, device bytes
// - 9fh returns maker, type, capacity bytes
// - ident read ignored while wipe runs
// - select release ends id output anywhere
// - 4bh, address, dummy: 128 unique bits
// - unique id is fixed, never writable
// - two otp registers wiped independently
// - 44h plus address: otp wipe, sector time
// - otp register chosen by address bits 15-12
// - locked otp register ignores wipe
`ifndef FLASH_CMD_DEFINES_SVH
`define FLASH_CMD_DEFINES_SVH
`define CLK_MHZ              10
`define OP_WRITE_ENABLE      8'h06
`define OP_BLOCK32           8'h52
`define OP_BLOCK64           8'hd8
`define OP_CHIP_A            8'h60
`define OP_CHIP_B            8'hc7
`define OP_MAKER_DEV         8'h90
`define OP_IDENT             8'h9f
`define OP_UNIQUE            8'h4b
`define OP_OTP_WIPE          8'h44
`define OP_BITS              8'h08
`define ADDR_CMD_BITS        8'h20
`define IDENT_START          8'h08
`define IDENT_END            8'h20
`define MAKER_DEV_START      8'h20
`define UNIQUE_START         8'h28
`define UNIQUE_END           8'ha8
`define BLOCK32_WIPE_TIME_US 150000
`define BLOCK64_WIPE_TIME_US 250000
`define FULL_WIPE_TIME_US    8000000
`define SECTOR_WIPE_TIME_US  45000
`define ARRAY_BLOCKS         7'h20
`endif

/* hdl/flash_cmd_pkg.sv */
// Purpose: types of the erase and identification command block
// Assumes: nothing
// Notes: enums carry no codes
package flash_cmd_pkg;
  // which wipe is running or was last started
  typedef enum logic [2:0] {WIPE_NONE, WIPE_BLOCK32, WIPE_BLOCK64, WIPE_CHIP, WIPE_OTP0, WIPE_OTP1} wipe_kind_t;
  // engine states
  typedef enum logic {ST_IDLE, ST_WIPE} engine_state_t;
endpackage

/* hdl/sync_agree3.sv */
// Purpose: three-stage synchroniser, output moves when stages two and three agree
// Assumes: din is from another clock or a pin
// Notes: stage one feeds stage two only
`timescale 1ns/1ns
module sync_agree3 #(
  parameter logic INIT = 1'b0
) (
  input  wire logic clk,
  input  wire logic rst_n,
  input  wire logic din,
  output logic      dout
);
  logic s1_q;  // metastable stage
  logic s2_q;  // second stage
  logic s3_q;  // third stage

  // shift chain and agreement filter
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      s1_q <= INIT;
      s2_q <= INIT;
      s3_q <= INIT;
      dout <= INIT;
    end
    else
    begin
      s1_q <= din;
      s2_q <= s1_q;
      s3_q <= s2_q;
      if (s2_q == s3_q)
        dout <= s3_q;
    end
  end
endmodule // sync_agree3

/* hdl/spi_link_shift.sv */
// Purpose: serial-clock side input shifter and frame request toggle
// Assumes: serial clock runs only while select is low
// Notes: counters clear while select is high; captured words hold after the frame
`timescale 1ns/1ns
module spi_link_shift (
  input  wire logic        sclk,
  input  wire logic        cs_n,
  input  wire logic        si,
  input  wire logic        ack,
  output logic [7:0]       bit_cnt_q,
  output logic [7:0]       opcode_q,
  output logic [31:0]      word_q,
  output logic [7:0]       last_cnt_q,
  output logic             req_q
);
  logic ack_s1_q;  // ack stage one
  logic ack_s2_q;  // ack stage two
  logic ack_s3_q;  // ack stage three
  logic ack_lk_q;  // ack once stages agree

  // bits taken this frame, saturating, ended by select
  always_ff @(posedge sclk or posedge cs_n)
  begin
    if (cs_n)
      bit_cnt_q <= 8'h00;
    else if (bit_cnt_q != 8'hff)
      bit_cnt_q <= bit_cnt_q + 8'h01;
  end

  // shift in, capture opcode, keep count past the frame
  always_ff @(posedge sclk)
  begin
    word_q   <= {word_q[30:0], si};
    ack_s1_q <= ack;
    ack_s2_q <= ack_s1_q;
    ack_s3_q <= ack_s2_q;
    if (ack_s2_q == ack_s3_q)
      ack_lk_q <= ack_s3_q;
    if (bit_cnt_q == 8'h07)
      opcode_q <= {word_q[6:0], si};
    if (bit_cnt_q == 8'h07)
      req_q <= ~ack_lk_q;
    last_cnt_q <= (bit_cnt_q == 8'hff) ? 8'hff : bit_cnt_q + 8'h01;
  end
endmodule // spi_link_shift

/* sim/spi_host_model.sv */
// Purpose: host side of the serial link, mode 0, msb first
// Assumes: link clock period 12 ns, still and low outside frames
// Notes: a released data line shows the inverse of its last bit
`timescale 1ns/1ns
module spi_host_model (
  output logic      sclk,
  output logic      cs_n,
  output logic      si,
  input  wire logic so,
  input  wire logic so_oe,
  output logic      oe_seen
);
  // idle link, select high
  initial
  begin
    sclk    = 1'b0;
    cs_n    = 1'b0;
    si      = 1'b0;
    oe_seen = 1'b0;
    // a clean select rise clears the link counters, which have no reset
    #1;
    cs_n    = 1'b1;
  end
  ////////////////////////////////////////////////////////////
  // one frame: select held low throughout, so sampled at each rise
  // never sends power-down; ident reads are still ignored while a wipe runs
  task automatic xfer(input logic [167:0] d, input int n, output logic [167:0] r);
    r       = '0;
    oe_seen = 1'b0;
    cs_n    = 1'b0;
    for (int i = 0; i < n; i++)
    begin
      si = d[n-1-i];
      #6;
      r = {r[166:0], so};
      if (so_oe)
        oe_seen = 1'b1;
      sclk = 1'b1;
      #6;
      sclk = 1'b0;
    end
    #6;
    cs_n = 1'b1;
    si   = ~si;
  endtask
endmodule  // spi_host_model

/* sim/serial_flash_erase_and_id_cmds_bench.sv */
// Purpose: self-checking bench of the erase and identification block
// Assumes: short wipe counts, host model on the link
// Notes: each scenario is a task that judges its own outcome
`timescale 1ns/1ns
module serial_flash_erase_and_id_cmds_bench
  import flash_cmd_pkg::*;
;
  localparam int B32 = 40;
  localparam int B64 = 60;
  localparam int FUL = 80;
  localparam int SEC = 30;
  logic          clk, rst_n, sclk, cs_n, si, so, so_oe, busy, latch, done, oe_seen;
  logic [4:0]    lv;       // protect levels
  logic          inv;      // protect invert
  logic [1:0]    lk;       // otp locks
  wipe_kind_t    kind;
  logic [23:0]   base;
  logic [167:0]  rd;       // bits seen on so
  int            err_total, compares;

  flash_erase_id #(.BLOCK32_CYC(B32), .BLOCK64_CYC(B64), .FULL_CYC(FUL), .SECTOR_CYC(SEC),
    .MAKER_CODE(8'h5a), .DEVICE_CODE(8'h14), .MEM_TYPE(8'h40), .CAPACITY(8'h15),
    .UNIQUE_ID(128'h0123_4567_89ab_cdef_fedc_ba98_7654_3210)) i_flash_erase_id (
    .clk(clk), .rst_n(rst_n), .sclk(sclk), .cs_n(cs_n), .si(si),
    .protect_level_0(lv[0]), .protect_level_1(lv[1]), .protect_level_2(lv[2]),
    .protect_level_3(lv[3]), .protect_level_4(lv[4]), .protect_invert(inv),
    .otp_lock_0(lk[0]), .otp_lock_1(lk[1]), .so(so), .so_oe(so_oe), .op_in_progress(busy),
    .write_latch_flag(latch), .wipe_kind(kind), .wipe_base(base), .wipe_done(done));

  spi_host_model i_spi_host_model (.sclk(sclk), .cs_n(cs_n), .si(si), .so(so), .so_oe(so_oe),
    .oe_seen(oe_seen));

  ////////////////////////////////////////////////////////////
  // clock, 100 ns
  initial
  begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end

  task automatic chk(input string what, input logic [127:0] seen, input logic [127:0] exp);
    compares++;
    if (seen !== exp)
    begin
      err_total++;
      $display("ERROR %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic tally_and_finish;
    $display("compares %0d err_total %0d", compares, err_total);
    if (err_total == 0 && compares > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  // one frame, then a gap of idle clocks
  task automatic send(input logic [167:0] d, input int n, input int gap);
    i_spi_host_model.xfer(d, n, rd);
    repeat (gap) @(posedge clk);
  endtask

  task automatic prot(input logic [4:0] l, input logic i, input logic [1:0] k);
    @(posedge clk);
    lv  <= l;
    inv <= i;
    lk  <= k;
  endtask

  // count busy clocks, bounded
  task automatic wait_idle(output int n);
    n = 0;
    while (busy === 1'b1 && n < 2000)
    begin
      @(posedge clk);
      #1;
      n++;
    end
    if (n >= 2000)
    begin
      err_total++;
      tally_and_finish;
    end
  endtask

  task automatic expect_wipe(input wipe_kind_t k, input logic [23:0] b, input int cyc);
    int n;
    n = 0;
    while (busy !== 1'b1 && n < 10)
    begin
      @(posedge clk);
      #1;
      n++;
    end
    chk("busy", busy, 1);
    chk("kind", kind, k);
    if (k == WIPE_BLOCK32 || k == WIPE_BLOCK64)
      chk("base", base, b);
    chk("latch", latch, 0);
    wait_idle(n);
    chk("busy cycles", n, cyc);
    chk("done", done, 1);
    repeat (8) @(posedge clk);
  endtask

  task automatic expect_none;
    repeat (12) @(posedge clk);
    chk("no wipe", busy, 0);
  endtask

  ////////////////////////////////////////////////////////////
  // identification reads, plus an early select release
  task automatic t_ident;
    chk("reset kind", kind, WIPE_NONE);
    send({8'h9f, 24'h0}, 32, 8);
    chk("ident", rd[23:0], 24'h5a4015);
    send(48'h90_000000_0000, 48, 8);
    chk("maker dev", rd[15:0], 16'h5a14);
    send({8'h4b, 32'h0, 128'h0}, 168, 8);
    chk("unique", rd[127:0], 128'h0123_4567_89ab_cdef_fedc_ba98_7654_3210);
    send(16'h9f00, 16, 1);
    chk("cut oe", so_oe, 0);
    repeat (8) @(posedge clk);
    send({8'h9f, 24'h0}, 32, 8);
    chk("ident again", rd[23:0], 24'h5a4015);
  endtask

  // block wipes, bad framing, latch and protection
  task automatic t_block;
    send(8'h06, 8, 8);
    chk("latch set", latch, 1);
    send({8'h52, 24'h01abcd}, 32, 0);
    expect_wipe(WIPE_BLOCK32, 24'h018000, B32);
    send(8'h06, 8, 8);
    send({8'hd8, 24'h1abcde}, 32, 0);
    expect_wipe(WIPE_BLOCK64, 24'h1a0000, B64);
    send({8'hd8, 24'h000000}, 32, 0);
    expect_none;
    send(8'h06, 8, 8);
    send({8'h52, 24'h0, 1'b0}, 33, 0);
    expect_none;
    send({8'h52, 23'h0}, 31, 0);
    expect_none;
    prot(5'h01, 1'b0, 2'b00);
    send({8'hd8, 24'h1f0000}, 32, 0);
    expect_none;
    prot(5'h09, 1'b0, 2'b00);
    send({8'hd8, 24'h000000}, 32, 0);
    expect_none;
    prot(5'h01, 1'b0, 2'b00);
    send({8'hd8, 24'h000000}, 32, 0);
    expect_wipe(WIPE_BLOCK64, 24'h000000, B64);
  endtask

  // both chip opcodes against the protect settings
  task automatic t_chip;
    logic [7:0] op [4] = '{8'h60, 8'hc7, 8'h60, 8'hc7};
    logic [2:0] l [4]  = '{3'h0, 3'h7, 3'h1, 3'h7};
    logic       iv [4] = '{1'b0, 1'b1, 1'b0, 1'b0};
    int         n;
    for (int i = 0; i < 4; i++)
    begin
      prot({2'b00, l[i]}, iv[i], 2'b00);
      send(8'h06, 8, 8);
      send(op[i], 8, 0);
      if (i < 2)
        expect_wipe(WIPE_CHIP, 24'h0, FUL);
      else
        expect_none;
    end
    prot(5'h00, 1'b0, 2'b00);
    send(8'h06, 8, 8);
    send(8'h60, 8, 12);
    send({8'h9f, 24'h0}, 32, 0);
    chk("busy ident oe", oe_seen, 0);
    chk("busy kept", busy, 1);
    wait_idle(n);
    repeat (8) @(posedge clk);
  endtask

  // otp register wipes, address decode and locks
  task automatic t_otp;
    prot(5'h00, 1'b0, 2'b01);
    send(8'h06, 8, 8);
    send({8'h44, 24'h001155}, 32, 0);
    expect_wipe(WIPE_OTP1, 24'h0, SEC);
    send(8'h06, 8, 8);
    send({8'h44, 24'h000000}, 32, 0);
    expect_none;
    prot(5'h00, 1'b0, 2'b00);
    send({8'h44, 24'h000400}, 32, 0);
    expect_none;
    send({8'h44, 24'h0003ff}, 32, 0);
    expect_wipe(WIPE_OTP0, 24'h0, SEC);
  endtask

  ////////////////////////////////////////////////////////////
  // reset, scenarios, verdict
  initial
  begin
    rst_n     = 1'b0;
    lv        = 5'h00;
    inv       = 1'b0;
    lk        = 2'b00;
    err_total = 0;
    compares  = 0;
    repeat (3) @(posedge clk);
    rst_n <= 1'b1;
    repeat (4) @(posedge clk);
    t_ident;
    t_block;
    t_chip;
    t_otp;
    tally_and_finish;
  end

  // hang guard
  initial
  begin
    #6000000;
    err_total++;
    tally_and_finish;
  end
endmodule  // serial_flash_erase_and_id_cmds_bench
